// >>> rtl/dma_event_pkg.sv
// Purpose: Shared constants for the DMA channel event and interrupt block.
// Assumes: Registers are 32-bit words reached over a plain strobe port.
// Notes:   Offsets are byte addresses on an 8-bit register address.
package dma_event_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CHAN_CTRL  = 8'h00;
   localparam logic [7:0] OFS_EVENT_CTRL = 8'h04;
   localparam logic [7:0] OFS_INT_CTRL   = 8'h08;

   // Channel control field positions.
   localparam int CTRL_CHANNEL_ON  = 7;
   localparam int CTRL_EVENTS_OFF  = 6;
   localparam int CTRL_AUTO_REEN   = 4;
   localparam int CTRL_EVENT_SEEN  = 2;

   // Event control field positions.
   localparam int EVT_ABORT_SEL_LO = 16;
   localparam int EVT_START_SEL_LO = 8;
   localparam int EVT_FORCE        = 7;
   localparam int EVT_SOFT_ABORT   = 6;
   localparam int EVT_PATTERN_EN   = 5;
   localparam int EVT_START_EN     = 4;
   localparam int EVT_ABORT_EN     = 3;

   // Interrupt control field positions.
   localparam int INT_IE_LO   = 16;
   localparam int INT_FLAG_LO = 0;

   // Flag indices inside the eight-bit flag and enable fields.
   localparam int FLG_SRC_DONE   = 7;
   localparam int FLG_SRC_HALF   = 6;
   localparam int FLG_DST_DONE   = 5;
   localparam int FLG_DST_HALF   = 4;
   localparam int FLG_BLOCK_DONE = 3;
   localparam int FLG_CELL_DONE  = 2;
   localparam int FLG_XFER_ABORT = 1;
   localparam int FLG_ADDR_ERR   = 0;

   // Reset values.
   localparam logic [7:0] RST_IRQ_SELECT = 8'hFF;
   localparam logic [7:0] RST_BYTE_ZERO  = 8'h00;
   localparam logic       RST_BIT_ZERO   = 1'b0;

   // Read data for unmapped addresses and idle cycles.
   localparam logic [31:0] READ_IDLE = 32'h0000_0000;

endpackage

// >>> rtl/dma_channel_event_irq_ctrl.sv
// Purpose: Event and interrupt logic of one DMA channel.
// Assumes: All inputs come from logic on clk; the transfer engine is outside.
// Notes:   Size fields of zero mean 65,536 bytes; counts are 17 bits wide.
module dma_channel_event_irq_ctrl
   import dma_event_pkg::*;
(
   input  wire logic        clk,          // System clock.
   input  wire logic        resetn,       // Synchronous reset, active low.
   input  wire logic [7:0]  regAddr,      // Register byte address.
   input  wire logic [31:0] regWrData,    // Register write data.
   input  wire logic        regWr,        // Write strobe.
   input  wire logic        regRd,        // Read strobe.
   output logic      [31:0] regRdData,    // Read data, valid the cycle after regRd.
   input  wire logic        irqEvent,     // A system interrupt occurred this cycle.
   input  wire logic [7:0]  irqNumber,    // Number of that interrupt.
   input  wire logic        xferStep,     // Engine updated pointers and counts.
   input  wire logic [16:0] srcPointer,   // Source bytes consumed.
   input  wire logic [16:0] dstPointer,   // Destination bytes written.
   input  wire logic [16:0] blockCount,   // Bytes moved in this block.
   input  wire logic [16:0] cellCount,    // Bytes moved in this cell.
   input  wire logic [15:0] srcSize,      // Programmed source size.
   input  wire logic [15:0] dstSize,      // Programmed destination size.
   input  wire logic [15:0] cellSize,     // Programmed cell size.
   input  wire logic        patternMatch, // Engine saw the data pattern.
   input  wire logic        addrError,    // Engine found an invalid address.
   output logic             startRequest, // Pulse: begin one cell transfer.
   output logic             abortRequest, // Pulse: abort the transfer.
   output logic             channelOn,    // Channel enable level.
   output logic             irqRequest    // Channel interrupt request level.
);

   // Expands a size field; zero stands for the full 65,536 bytes.
   function automatic logic [16:0] fullSize(input logic [15:0] size);
      fullSize = (size == 16'h0000) ? 17'h10000 : {1'b0, size};
   endfunction

   // Register state.
   logic [7:0]  abortSel_q;       // Aborting interrupt number.
   logic [7:0]  startSel_q;       // Starting interrupt number.
   logic        patternAbortEn_q; // Pattern match abort enable.
   logic        startOnIrqEn_q;   // Start on interrupt enable.
   logic        abortOnIrqEn_q;   // Abort on interrupt enable.
   logic        channelOn_q;      // Channel enable.
   logic        eventsWhenOff_q;  // Events accepted while disabled.
   logic        autoReenable_q;   // Stay enabled after each block.
   logic        eventSeen_q;      // A start event was detected.
   logic [7:0]  ie_q;             // Per-flag interrupt enables.
   logic [7:0]  flags_q;          // Sticky status flags.
   logic [7:0]  flags_d;          // Next flag values.
   logic        startRequest_q;   // Registered start pulse.
   logic        abortRequest_q;   // Registered abort pulse.
   logic        irqRequest_q;     // Registered interrupt request.
   logic [31:0] regRdData_q;      // Registered read data.

   // Address decode.
   wire         hitCtrl   = (regAddr == OFS_CHAN_CTRL);
   wire         hitEvent  = (regAddr == OFS_EVENT_CTRL);
   wire         hitInt    = (regAddr == OFS_INT_CTRL);
   wire         wrCtrl    = regWr && hitCtrl;
   wire         wrEvent   = regWr && hitEvent;
   wire         wrInt     = regWr && hitInt;

   // Interrupt events count while enabled, or while disabled when allowed.
   // Disabled channel gating.
   wire         eventsAllowed = channelOn_q || eventsWhenOff_q;

   wire         startIrqHit = irqEvent && (irqNumber == startSel_q);
   wire         abortIrqHit = irqEvent && (irqNumber == abortSel_q);

   wire         irqStart  = startIrqHit && startOnIrqEn_q && eventsAllowed;
   wire         irqAbort  = abortIrqHit && abortOnIrqEn_q && eventsAllowed;
   wire         forceStart = wrEvent && regWrData[EVT_FORCE];
   wire         softAbort  = wrEvent && regWrData[EVT_SOFT_ABORT];
   wire         patternAbort = patternMatch && patternAbortEn_q;

   // Every source of a start, and every source of an abort, gathered.
   wire         startEvent = irqStart || forceStart;
   wire         abortEvent = irqAbort || softAbort || patternAbort;

   // Byte-count compares made on each engine step.
   wire [16:0]  srcFull   = fullSize(srcSize);
   wire [16:0]  dstFull   = fullSize(dstSize);
   wire [16:0]  cellFull  = fullSize(cellSize);
   wire [16:0]  blockFull = (srcFull > dstFull) ? srcFull : dstFull;

   wire         srcDoneHit  = xferStep && (srcPointer == srcFull);
   wire         srcHalfHit  = xferStep && (srcPointer == {1'b0, srcFull[16:1]});
   wire         dstDoneHit  = xferStep && (dstPointer == dstFull);
   wire         dstHalfHit  = xferStep && (dstPointer == {1'b0, dstFull[16:1]});
   wire         blockHit    = (xferStep && (blockCount == blockFull)) || patternMatch;
   wire         cellHit     = xferStep && (cellCount == cellFull);

   // Hardware set terms, one per flag, in flag order.
   wire [7:0]   flagSet = {srcDoneHit, srcHalfHit, dstDoneHit, dstHalfHit,
                           blockHit, cellHit,
                           irqAbort,   // Abort flag source.
                           addrError}; // Address error source.

   // Sticky flags, set wins over a clear write.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign flags_d[gi] = flagSet[gi] ||
                              (flags_q[gi] && !(wrInt && !regWrData[INT_FLAG_LO + gi]));
      end
   endgenerate

   // Read data assembly; unimplemented bits are constant zero.
   // Zero reserved bits.
   wire [31:0]  ctrlRead  = {24'h000000, channelOn_q, eventsWhenOff_q, 1'b0,
                             autoReenable_q, 1'b0, eventSeen_q, 2'b00};
   wire [31:0]  eventRead = {8'h00, abortSel_q, startSel_q, 2'b00, patternAbortEn_q,
                             startOnIrqEn_q, abortOnIrqEn_q, 3'b000};
   wire [31:0]  intRead   = {8'h00, ie_q, 8'h00, flags_q};
   wire [31:0]  readMux   = hitCtrl  ? ctrlRead  :
                            hitEvent ? eventRead :
                            hitInt   ? intRead   : READ_IDLE;

   // Next channel enable: software write wins, else hardware may clear it.
   // Block done disable.
   wire         chanOff   = patternAbort || (blockHit && !autoReenable_q);
   wire         channelOn_d = wrCtrl ? regWrData[CTRL_CHANNEL_ON]
                                     : (channelOn_q && !chanOff);

   // Event seen, set wins over the end of a transfer.
   wire         eventSeen_d = startEvent ||
                              (eventSeen_q && !(abortEvent || blockHit));

   // Event control register; the force and abort bits are not stored.
   // Reset values.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         abortSel_q       <= RST_IRQ_SELECT;
         startSel_q       <= RST_IRQ_SELECT;
         patternAbortEn_q <= RST_BIT_ZERO;
         startOnIrqEn_q   <= RST_BIT_ZERO;
         abortOnIrqEn_q   <= RST_BIT_ZERO;
      end else if (wrEvent) begin
         abortSel_q       <= regWrData[EVT_ABORT_SEL_LO +: 8];
         startSel_q       <= regWrData[EVT_START_SEL_LO +: 8];
         patternAbortEn_q <= regWrData[EVT_PATTERN_EN];
         startOnIrqEn_q   <= regWrData[EVT_START_EN];
         abortOnIrqEn_q   <= regWrData[EVT_ABORT_EN];
      end
   end

   // Channel control register.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         channelOn_q     <= RST_BIT_ZERO;
         eventsWhenOff_q <= RST_BIT_ZERO;
         autoReenable_q  <= RST_BIT_ZERO;
         eventSeen_q     <= RST_BIT_ZERO;
      end else begin
         channelOn_q <= channelOn_d;
         eventSeen_q <= eventSeen_d;
         if (wrCtrl) begin
            eventsWhenOff_q <= regWrData[CTRL_EVENTS_OFF];
            autoReenable_q  <= regWrData[CTRL_AUTO_REEN];
         end
      end
   end

   // Interrupt enables and flags.
   // Enable field write.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ie_q    <= RST_BYTE_ZERO;
         flags_q <= RST_BYTE_ZERO;
      end else begin
         flags_q <= flags_d;
         if (wrInt) begin
            ie_q <= regWrData[INT_IE_LO +: 8];
         end
      end
   end

   // Output pulses, request level and read data, all registered.
   // Masked interrupt request.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         startRequest_q <= RST_BIT_ZERO;
         abortRequest_q <= RST_BIT_ZERO;
         irqRequest_q   <= RST_BIT_ZERO;
         regRdData_q    <= READ_IDLE;
      end else begin
         startRequest_q <= startEvent;
         abortRequest_q <= abortEvent;
         irqRequest_q   <= |(flags_q & ie_q);
         regRdData_q    <= regRd ? readMux : READ_IDLE;
      end
   end

   // Every output is driven straight from its flip-flop.
   assign regRdData    = regRdData_q;
   assign startRequest = startRequest_q;
   assign abortRequest = abortRequest_q;
   assign channelOn    = channelOn_q;
   assign irqRequest   = irqRequest_q;

   // Checks run on clk and stand still during reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // A write of the event control register with a chosen bit set.
   sequence seqForceWrite;
      regWr && (regAddr == OFS_EVENT_CTRL) && regWrData[EVT_FORCE];
   endsequence
   sequence seqSoftAbortWrite;
      regWr && (regAddr == OFS_EVENT_CTRL) && regWrData[EVT_SOFT_ABORT];
   endsequence
   // A read strobe of one register.
   sequence seqEventRead;
      regRd && (regAddr == OFS_EVENT_CTRL);
   endsequence
   sequence seqIntRead;
      regRd && (regAddr == OFS_INT_CTRL);
   endsequence

   chk_force_start: assert property (seqForceWrite |=> startRequest_q)
      else $error("Forced transfer write did not start a transfer.");

   chk_soft_abort: assert property (seqSoftAbortWrite |=> abortRequest_q)
      else $error("Software abort write did not abort.");

   chk_irq_start: assert property (
      irqEvent && (irqNumber == startSel_q) && startOnIrqEn_q && channelOn_q
      |=> startRequest_q ##1 (!startRequest_q || $past(irqEvent) || $past(regWr)))
      else $error("Enabled start interrupt gave no single start pulse.");

   chk_start_ignored: assert property (
      !startOnIrqEn_q && !forceStart || !channelOn_q && !eventsWhenOff_q && !forceStart
      |=> !startRequest_q)
      else $error("Start pulse without an accepted start event.");

   chk_abort_flag: assert property (
      irqEvent && (irqNumber == abortSel_q) && abortOnIrqEn_q && eventsAllowed
      |=> flags_q[FLG_XFER_ABORT] && abortRequest_q)
      else $error("Accepted abort interrupt did not set the abort flag.");

   chk_event_zero: assert property (seqEventRead |=>
      (regRdData_q[31:24] == 8'h00) && (regRdData_q[7:6] == 2'b00)
      && (regRdData_q[2:0] == 3'b000))
      else $error("Event control unimplemented bits read nonzero.");

   chk_int_zero: assert property (seqIntRead |=>
      (regRdData_q[31:24] == 8'h00) && (regRdData_q[15:8] == 8'h00))
      else $error("Interrupt control unimplemented bits read nonzero.");

   chk_flag_sticky: assert property (
      flags_q[FLG_ADDR_ERR] && !(wrInt && !regWrData[INT_FLAG_LO + FLG_ADDR_ERR])
      |=> flags_q[FLG_ADDR_ERR])
      else $error("Sticky flag dropped without a clearing write.");

   chk_irq_level: assert property (
      (flags_q[FLG_CELL_DONE] && ie_q[FLG_CELL_DONE]) [*2] |-> irqRequest_q)
      else $error("Enabled pending flag raised no interrupt request.");

   chk_block_off: assert property (
      blockHit && !autoReenable_q && !wrCtrl |=> !channelOn_q)
      else $error("Block completion left the channel enabled.");

   chk_pattern_off: assert property (
      patternMatch && patternAbortEn_q && !wrCtrl
      |=> !channelOn_q && abortRequest_q && flags_q[FLG_BLOCK_DONE])
      else $error("Pattern abort did not abort and disable.");

   chk_reset_select: assert property (
      $rose(resetn) |-> (abortSel_q == RST_IRQ_SELECT) && (startSel_q == RST_IRQ_SELECT)
      && (flags_q == RST_BYTE_ZERO) && (ie_q == RST_BYTE_ZERO))
      else $error("Reset values wrong after reset release.");

   // Pointer and count compares, rebuilt here from the size fields alone.
   // A zero size field stands for the full span, so these checks expand it too.

   // Source pointer at the full size marks the source as done.
   chk_src_done: assert property (
      xferStep && (srcPointer == fullSize(srcSize)) |=> flags_q[FLG_SRC_DONE])
      else $error("Source pointer at size left the source done flag clear.");

   // Source pointer at half the size marks the source as half empty.
   chk_src_half: assert property (
      xferStep && (srcPointer == (fullSize(srcSize) >> 1)) |=> flags_q[FLG_SRC_HALF])
      else $error("Source pointer at half size left the source half flag clear.");

   // Destination pointer at the full size marks the destination as done.
   chk_dst_done: assert property (
      xferStep && (dstPointer == fullSize(dstSize)) |=> flags_q[FLG_DST_DONE])
      else $error("Destination pointer at size left the done flag clear.");

   // Destination pointer at half the size marks the destination as half full.
   chk_dst_half: assert property (
      xferStep && (dstPointer == (fullSize(dstSize) >> 1)) |=> flags_q[FLG_DST_HALF])
      else $error("Destination pointer at half size left the half flag clear.");

   // Any pattern match completes the block, whether it aborts or not.
   chk_block_flag: assert property (patternMatch |=> flags_q[FLG_BLOCK_DONE])
      else $error("Pattern match did not set the block complete flag.");

   // A cell count at the cell size marks the cell as complete.
   chk_cell_flag: assert property (
      xferStep && (cellCount == fullSize(cellSize)) |=> flags_q[FLG_CELL_DONE])
      else $error("Cell count at cell size left the cell flag clear.");

   // An address error from the engine is always recorded.
   chk_addr_flag: assert property (addrError |=> flags_q[FLG_ADDR_ERR])
      else $error("Address error did not set its flag.");

   // A forced start is a start event and must be recorded as seen.
   chk_event_seen: assert property (seqForceWrite |=> eventSeen_q)
      else $error("Forced start left the event seen bit clear.");

   // A lone software abort with no start beside it ends the event record.
   chk_abort_clears: assert property (
      regWr && (regAddr == OFS_EVENT_CTRL) && regWrData[EVT_SOFT_ABORT]
      && !regWrData[EVT_FORCE] && !irqEvent |=> !eventSeen_q)
      else $error("Abort left the event seen bit set.");

   // An abort interrupt with its enable clear must not abort on its own.
   chk_abort_ignored: assert property (
      irqEvent && (irqNumber == abortSel_q) && !abortOnIrqEn_q && !patternMatch
      && !(regWr && (regAddr == OFS_EVENT_CTRL)) |=> !abortRequest_q)
      else $error("Disabled abort interrupt still aborted.");

   // A software write that sets the enable wins over a hardware clear.
   chk_write_on: assert property (
      regWr && (regAddr == OFS_CHAN_CTRL) && regWrData[CTRL_CHANNEL_ON] |=> channelOn_q)
      else $error("Enable write did not leave the channel enabled.");

   // Read data stand only in the cycle after a read strobe.
   chk_read_idle: assert property (!regRd |=> regRdData_q == READ_IDLE)
      else $error("Read data nonzero without a read strobe.");

   // No enabled flag pending for two cycles means no request.
   chk_irq_quiet: assert property (
      ((flags_q & ie_q) == 8'h00) [*2] |-> !irqRequest_q)
      else $error("Interrupt request raised with no enabled flag pending.");

endmodule

// >>> bench/irq_source_model.sv
// Purpose: Model of the system interrupt sources that feed the channel.
// Assumes: One interrupt is signalled as a one-cycle pulse with its number.
// Notes:   After a pulse the number shows its inverse so a stale value never matches.
module irq_source_model (
   input  wire logic       clk,       // System clock.
   output logic            irqEvent,  // Pulse: an interrupt occurred.
   output logic      [7:0] irqNumber  // Number of that interrupt.
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle values before the first interrupt.
   initial begin
      irqEvent  = 1'b0;
      irqNumber = 8'h00;
   end

   // Raises one interrupt for a single cycle, then scrambles the number.
   task automatic raise(input logic [7:0] num);
      @(posedge clk);
      irqEvent  <= 1'b1;
      irqNumber <= num;
      @(posedge clk);
      irqEvent  <= 1'b0;
      irqNumber <= ~num;
      #1;
   endtask
endmodule

// >>> bench/test_dma_channel_event_irq_ctrl.sv
// Purpose: Self-checking bench of the channel event and interrupt block.
// Assumes: Registers at the package offsets; events are one-cycle pulses.
// Notes:   Every scenario is its own task and judges its own results.
module test_dma_channel_event_irq_ctrl;
   import dma_event_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, resetn, regWr, regRd, xferStep, patternMatch, addrError;
   logic [7:0]  regAddr;
   logic [31:0] regWrData, regRdData;
   logic [16:0] srcPointer, dstPointer, blockCount, cellCount;
   logic [15:0] srcSize, dstSize, cellSize;
   logic        irqEvent, startRequest, abortRequest, channelOn, irqRequest;
   logic [7:0]  irqNumber;
   int          n_mismatch, total_checks;

   dma_channel_event_irq_ctrl u_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .irqEvent(irqEvent), .irqNumber(irqNumber), .xferStep(xferStep),
      .srcPointer(srcPointer), .dstPointer(dstPointer), .blockCount(blockCount),
      .cellCount(cellCount), .srcSize(srcSize), .dstSize(dstSize), .cellSize(cellSize),
      .patternMatch(patternMatch), .addrError(addrError), .startRequest(startRequest),
      .abortRequest(abortRequest), .channelOn(channelOn), .irqRequest(irqRequest));

   // The interrupt sources sit on the far side.
   irq_source_model u_src (.clk(clk), .irqEvent(irqEvent), .irqNumber(irqNumber));

   // Clock of 5 ns period.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Compares one value and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask

   // One-cycle register read, checked in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask

   // One engine step with the given pointers and counts.
   task automatic step(input logic [16:0] s, d, b, c);
      @(posedge clk);
      xferStep <= 1'b1; srcPointer <= s; dstPointer <= d; blockCount <= b; cellCount <= c;
      @(posedge clk);
      xferStep <= 1'b0;
      #1;
   endtask

   // Pulses pattern match or address error for one cycle.
   task automatic hit(input bit pat);
      @(posedge clk);
      patternMatch <= pat;
      addrError    <= !pat;
      @(posedge clk);
      patternMatch <= 1'b0; addrError <= 1'b0;
      #1;
   endtask

   // Loads the three size fields just after a clock edge.
   task automatic set_sizes(input logic [15:0] s, d, c);
      @(posedge clk);
      srcSize  <= s;
      dstSize  <= d;
      cellSize <= c;
      #1;
   endtask

   // Reset values, write-only bits, reserved bits and an unmapped place.
   task automatic t_regs();
      rd(OFS_EVENT_CTRL, 32'h00FF_FF00); // selectors reset high
      rd(OFS_INT_CTRL, 32'h0000_0000); // enables and flags low
      wr(OFS_EVENT_CTRL, 32'hFFFF_FFFF);
      chk({startRequest, abortRequest}, 32'h3); // force and abort act
      rd(OFS_EVENT_CTRL, 32'h00FF_FF38); // read zero
      wr(OFS_INT_CTRL, 32'hFFFF_FFFF);
      rd(OFS_INT_CTRL, 32'h00FF_0000); // ones keep flags clear
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0000_0000); // unmapped reads zero
      wr(OFS_INT_CTRL, 32'h0000_0000);
   endtask

   // Start interrupts: selector, enable, channel off and events when off.
   task automatic t_start();
      wr(OFS_CHAN_CTRL, 32'h0000_0080);
      wr(OFS_EVENT_CTRL, 32'h00FF_2A50);
      rd(OFS_CHAN_CTRL, 32'h0000_0080); // abort leaves nothing seen
      u_src.raise(8'h2A);
      chk(startRequest, 32'h1); // matching start
      rd(OFS_CHAN_CTRL, 32'h0000_0084); // event seen
      u_src.raise(8'h2B);
      chk(startRequest, 32'h0); // other number ignored
      wr(OFS_EVENT_CTRL, 32'h00FF_2A00);
      u_src.raise(8'h2A);
      chk(startRequest, 32'h0); // enable clear
      wr(OFS_CHAN_CTRL, 32'h0000_0000);
      wr(OFS_EVENT_CTRL, 32'h00FF_2A10);
      u_src.raise(8'h2A);
      chk(startRequest, 32'h0); // off and not allowed
      wr(OFS_CHAN_CTRL, 32'h0000_0040);
      u_src.raise(8'h2A);
      chk(startRequest, 32'h1); // allowed while off
   endtask

   // Abort interrupts set the sticky abort flag and the request.
   task automatic t_abort();
      wr(OFS_CHAN_CTRL, 32'h0000_0080);
      wr(OFS_INT_CTRL, 32'h0002_0000);
      wr(OFS_EVENT_CTRL, 32'h0055_FF00);
      u_src.raise(8'h55);
      chk(abortRequest, 32'h0); // enable clear
      wr(OFS_EVENT_CTRL, 32'h0055_FF08);
      u_src.raise(8'h55);
      chk(abortRequest, 32'h1); // matching abort
      @(posedge clk);
      #1;
      chk(irqRequest, 32'h1); // enabled flag raises request
      rd(OFS_INT_CTRL, 32'h0002_0002); // abort flag set
      wr(OFS_INT_CTRL, 32'h0002_0000);
      rd(OFS_INT_CTRL, 32'h0002_0000); // zero clears flag
      chk(irqRequest, 32'h0); // request drops
   endtask

   // Pattern match and block completion against the channel enable.
   task automatic t_pattern();
      wr(OFS_INT_CTRL, 32'h0000_0000);
      wr(OFS_EVENT_CTRL, 32'h00FF_FF20);
      hit(1'b1);
      chk({abortRequest, channelOn}, 32'h2); // abort and disable
      rd(OFS_INT_CTRL, 32'h0000_0008); // pattern completes block
      wr(OFS_EVENT_CTRL, 32'h00FF_FF00);
      wr(OFS_CHAN_CTRL, 32'h0000_0090);
      hit(1'b1);
      chk({abortRequest, channelOn}, 32'h1); // auto keeps enable
      wr(OFS_CHAN_CTRL, 32'h0000_0080);
      step(17'd1, 17'd1, 17'd16, 17'd1);
      chk(channelOn, 32'h0); // block end disables
   endtask

   // Pointer flags, address error and each enable in its own place.
   task automatic t_flags();
      set_sizes(16'd8, 16'd4, 16'd2);
      wr(OFS_INT_CTRL, 32'h0000_0000);
      step(17'd4, 17'd2, 17'd4, 17'd2);
      rd(OFS_INT_CTRL, 32'h0000_0054); // halves and cell
      wr(OFS_INT_CTRL, 32'h0000_0000);
      step(17'd8, 17'd4, 17'd8, 17'd1);
      rd(OFS_INT_CTRL, 32'h0000_00A8); // dones and block
      set_sizes(16'h0000, 16'h0000, 16'h0000);
      wr(OFS_INT_CTRL, 32'h0000_0000);
      step(17'h10000, 17'h08000, 17'h10000, 17'h10000);
      rd(OFS_INT_CTRL, 32'h0000_009C); // zero size is full span
      wr(OFS_INT_CTRL, 32'h0000_0000);
      hit(1'b0);
      rd(OFS_INT_CTRL, 32'h0000_0001); // address error
      for (int i = 0; i < 8; i++) begin
         wr(OFS_INT_CTRL, (32'h1 << (16 + i)) | 32'h1);
         repeat (2) @(posedge clk);
         #1;
         chk(irqRequest, (i == 0) ? 32'h1 : 32'h0); // enable matches own flag
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Cuts a hang short well after the tests should end.
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end

   // Main sequence: reset for eight cycles, then every scenario.
   initial begin
      n_mismatch = 0; total_checks = 0;
      resetn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWrData = 32'h0;
      xferStep = 1'b0; patternMatch = 1'b0; addrError = 1'b0;
      srcPointer = 17'h0; dstPointer = 17'h0; blockCount = 17'h0; cellCount = 17'h0;
      srcSize = 16'h10; dstSize = 16'h10; cellSize = 16'h10;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_start();
      t_abort();
      t_pattern();
      t_flags();
      stop_test();
   end
endmodule
